// >>> dv/tcwp_checker_sva.sv
`timescale 1ns/1ps

module tcwp_checker (
    input wire clk, // Clock
    input wire reset, // Sync reset
    input wire psel, // APB select
    input wire penable, // APB enable
    input wire pwrite, // APB direction
    input wire [7:0] paddr, // APB address
    input wire [31:0] pwdata, // APB write data
    input wire [31:0] prdata, // APB read data
    input wire pready, // APB ready
    input wire pslverr, // APB error
    input wire [3:0] channelOutput, // Compare pins
    input wire timerOverflowFlag // Overflow flag
);
    // ----------------------------------------
    // Shadow of run bit and top buffer
    // ----------------------------------------
    logic runR;
    logic [15:0] topR;
    wire wrAcc = psel && penable && pwrite;
    wire rdAcc = psel && penable && !pwrite;
    always @(posedge clk) begin
        if (reset) begin
            runR <= 1'b0;
            topR <= 16'hffff;
        end else if (wrAcc && paddr == 8'h00) begin
            runR <= pwdata[0];
        end else if (wrAcc && paddr == 8'h04) begin
            topR <= pwdata[15:0];
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    sequence stopped3;
        !runR [*3];
    endsequence
    // ----------------------------------------
    // Properties
    // ----------------------------------------
    reset_outputs_a: assert property ($fell(reset) |-> channelOutput == 4'hf && !timerOverflowFlag)
        else $error("outputs wrong after reset");
    ready_follows_a: assert property (pready == penable)
        else $error("pready not equal to penable");
    misalign_err_a: assert property (psel && penable && paddr[1:0] != 2'h0 |-> pslverr)
        else $error("misaligned access without error");
    err_only_access_a: assert property (pslverr |-> psel && penable)
        else $error("error outside access phase");
    err_read_zero_a: assert property (rdAcc && pslverr |-> prdata == 32'h0)
        else $error("refused read returned data");
    upper_zero_a: assert property (rdAcc |-> prdata[31:16] == 16'h0)
        else $error("upper read bits not zero");
    top_readback_a: assert property (rdAcc && paddr == 8'h04 |-> prdata == {16'h0, topR})
        else $error("top readback mismatch");
    stopped_hold_a: assert property (stopped3 |=> $stable(channelOutput))
        else $error("output moved while stopped");
    flag_needs_run_a: assert property ($rose(timerOverflowFlag) |-> $past(runR) || $past(runR, 2))
        else $error("flag set while stopped");
    flag_sticky_a: assert property (timerOverflowFlag && !(wrAcc && paddr == 8'h0c) |=> timerOverflowFlag)
        else $error("flag dropped without clear");
endmodule

bind tcwp_waveform tcwp_checker chk (.clk(clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .channelOutput(channelOutput), .timerOverflowFlag(timerOverflowFlag));

// >>> dv/timer_compare_waveform_pwm_bench.sv
`timescale 1ns/1ps

module timer_compare_waveform_pwm_bench;
    logic clk, reset, psel, penable, pwrite, pready, pslverr, flag;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [3:0] chOut;
    int mismatches = 0, checkCount = 0, cyc = 0, hi[4], rs[4], g;

    tcwp_waveform dut (.clk(clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .channelOutput(chOut), .timerOverflowFlag(flag));

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            mismatches++;
            complete_run();
        end
    end
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    task complete_run();
        $display("checks %0d mismatches %0d", checkCount, mismatches);
        if (mismatches == 0 && checkCount > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        checkCount++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task apb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q, output logic e);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1 && cyc < 20000);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic e;
        apb(1'b1, a, d, q, e);
    endtask
    task rd(input logic [7:0] a, input logic [31:0] exp, input logic expErr);
        logic [31:0] q;
        logic e;
        apb(1'b0, a, 32'h0, q, e);
        chk(q, exp);
        chk({31'h0, e}, {31'h0, expErr});
    endtask
    task chan(input int n, input logic [7:0] ctl, input logic [15:0] cmp);
        wr(8'h10 + 8'(4 * n), {24'h0, ctl});
        wr(8'h20 + 8'(4 * n), {16'h0, cmp});
    endtask
    // Count high cycles and rising edges per pin after settling
    task meas(input int n);
        logic [3:0] prev;
        repeat (40) @(posedge clk);
        hi = '{0, 0, 0, 0};
        rs = '{0, 0, 0, 0};
        @(negedge clk);
        prev = chOut;
        repeat (n) begin
            @(negedge clk);
            for (int b = 0; b < 4; b++) begin
                hi[b] += int'(chOut[b] === 1'b1);
                rs[b] += int'(chOut[b] === 1'b1 && prev[b] === 1'b0);
            end
            prev = chOut;
        end
    endtask
    task waitFlag();
        int k;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (flag !== 1'b1 && k < 100);
    endtask
    task flagGap(output int gap);
        int t;
        wr(8'h0c, 32'h1);
        waitFlag();
        t = cyc;
        wr(8'h0c, 32'h1);
        waitFlag();
        gap = cyc - t;
    endtask
    // ----------------------------------------
    // Tests
    // ----------------------------------------
    initial begin
        reset = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h0;
        pwdata = 32'h0;
        repeat (20) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        chk(chOut, 4'hf);
        chk(flag, 1'b0);
        rd(8'h04, 32'hffff, 1'b0);
        rd(8'h00, 32'h0, 1'b0);
        rd(8'h0c, 32'h3c, 1'b0);
        rd(8'h40, 32'h0, 1'b1);
        rd(8'h05, 32'h0, 1'b1);
        $display("test reset done");
        wr(8'h04, 32'h9);
        chan(0, 8'h0b, 16'h3);
        chan(1, 8'h09, 16'h3);
        chan(2, 8'h0b, 16'h0);
        chan(3, 8'h0b, 16'hc);
        // Start on the wrap so the new top loads at once
        wr(8'h08, 32'hffff);
        wr(8'h00, 32'h5);
        meas(40);
        chk(hi[0], 28);
        chk(hi[1], 12);
        chk(hi[2], 40);
        chk(hi[3], 0);
        chk(rs[0], 4);
        wr(8'h00, 32'h1005);
        meas(40);
        chk(hi[0], 28);
        chk(rs[0], 2);
        chan(0, 8'h0b, 16'h5);
        meas(40);
        chk(hi[0], 20);
        $display("test asymmetric done");
        wr(8'h00, 32'h0);
        wr(8'h04, 32'ha);
        chan(0, 8'h0b, 16'h4);
        chan(1, 8'h09, 16'h4);
        wr(8'h00, 32'h9);
        meas(40);
        chk(hi[0], 16);
        chk(hi[1], 24);
        chk(hi[2], 0);
        chk(hi[3], 40);
        chk(rs[0], 2);
        flagGap(g);
        chk(g, 20);
        wr(8'h00, 32'hd);
        meas(40);
        chk(hi[0], 16);
        flagGap(g);
        chk(g, 10);
        $display("test symmetric done");
        wr(8'h00, 32'h0);
        wr(8'h04, 32'hffff);
        chan(0, 8'h17, 16'h4);
        chan(1, 8'h00, 16'h0);
        chan(2, 8'h03, 16'h2);
        chan(3, 8'h05, 16'h3);
        wr(8'h00, 32'h5);
        meas(40);
        chk(hi[0], 20);
        chk(rs[0], 4);
        chk(hi[2], 40);
        chk(hi[3], 0);
        $display("test clear on match done");
        wr(8'h00, 32'h0);
        wr(8'h04, 32'h9);
        chan(0, 8'h0b, 16'h3);
        chan(1, 8'h0b, 16'h3);
        chan(2, 8'h0b, 16'h3);
        wr(8'h00, 32'h20);
        wr(8'h08, 32'hffff);
        wr(8'h00, 32'h25);
        meas(40);
        chk(hi[0], 14);
        chk(hi[1], 14);
        chk(hi[2], 28);
        chk(hi[3], 0);
        $display("test phase done");
        complete_run();
    end
endmodule

// >>> hw/tcwp_defines.vh
`ifndef TCWP_DEFINES_VH
`define TCWP_DEFINES_VH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define TCWP_CTRL_ADDR 8'h00
`define TCWP_TOP_ADDR 8'h04
`define TCWP_COUNT_ADDR 8'h08
`define TCWP_STAT_ADDR 8'h0c
`define TCWP_CHCTL_PAGE 4'h1
`define TCWP_CHVAL_PAGE 4'h2

// ----------------------------------------
// Control register fields
// ----------------------------------------
`define TCWP_CTRL_RUN 0
`define TCWP_CTRL_CRS 1
`define TCWP_CTRL_CM_LO 2
`define TCWP_CTRL_CM_HI 3
`define TCWP_CTRL_UDE 4
`define TCWP_CTRL_PHS_LO 5
`define TCWP_CTRL_PHS_HI 7
`define TCWP_CTRL_PHASE_DIRECTION 8
`define TCWP_CTRL_TPS_LO 12
`define TCWP_CTRL_TPS_HI 15

// ----------------------------------------
// Channel control fields
// ----------------------------------------
`define TCWP_CH_CCM 0
`define TCWP_CH_ACT_LO 1
`define TCWP_CH_ACT_HI 3
`define TCWP_CH_CTC 4

// ----------------------------------------
// Reset values
// ----------------------------------------
`define TCWP_CTRL_RST 16'h0000
`define TCWP_TOP_RST 16'hffff
`define TCWP_FULL_TOP 16'hffff

// ----------------------------------------
// Encodings
// ----------------------------------------
`define TCWP_CM_EDGE 2'h1
`define TCWP_CM_PFC 2'h2
`define TCWP_CM_PC 2'h3
`define TCWP_ACT_SET 3'h1
`define TCWP_ACT_CLR 3'h2
`define TCWP_ACT_TGL 3'h3
`define TCWP_ACT_PWM 2'h2
`define TCWP_PHS_OFF 3'h0
`define TCWP_PHS_1OF2 3'h1
`define TCWP_PHS_1OF3 3'h2
`define TCWP_PHS_1OF4 3'h3
`define TCWP_PHS_2OF4 3'h4

`endif

// >>> hw/tcwp_waveform.v
// Overview of operation
// - Auto-reload with count mode 01 counts up to top, compare points place edges.
// - Outside up/down counting, clear-on-match enable resets the timer to zero after that channel's match.
// - Auto-reload with count mode 1x counts up and down, edges on both slopes.
// - Compare actions happen only for values the timer actually reaches.
// - Compare select 1 with action 10x gives PWM with a double-buffered compare value.
// - Asymmetric PWM counts zero to top, then restarts from zero.
// - Asymmetric non-inverting goes high on match, low at zero; inverting the opposite.
// - Asymmetric top and compare buffers load only at the top-to-zero wrap.
// - Asymmetric period is top plus one ticks, each tick prescale plus one clocks.
// - Asymmetric: compare at or above top holds low, zero holds high (non-inverting).
// - Symmetric PWM counts up to top and back to zero, top held one tick.
// - Symmetric non-inverting clears on up match, sets on down match; inverting opposite.
// - Symmetric top loads only at underflow; compare value is double-buffered.
// - Symmetric period is twice top ticks, each tick prescale plus one clocks.
// - Symmetric: compare at or above top holds high, zero holds low (non-inverting).
// - Count mode 10 loads compare buffers and sets overflow flag only at underflow.
// - Count mode 11 loads compare buffers and sets overflow flag at underflow and top.
// - Phase modes 1 to 3 enable channels in one-hot turn, mode 4 in pairs A,C and B,D; direction reverses order.
// - Non-PWM channels ignore sequencing; C,D in 1:2 and D in 1:3 run normally.
// - Reset drives every channel output to one.
`timescale 1ns/1ps
`include "tcwp_defines.vh"

module tcwp_waveform (
    input wire clk, // System clock
    input wire reset, // Synchronous reset
    input wire psel, // APB select
    input wire penable, // APB enable
    input wire pwrite, // APB direction
    input wire [7:0] paddr, // APB byte address
    input wire [31:0] pwdata, // APB write data
    output wire [31:0] prdata, // APB read data
    output wire pready, // APB ready
    output wire pslverr, // APB error
    output wire [3:0] channelOutput, // Compare output pins A..D
    output wire timerOverflowFlag // Sticky overflow flag
);

    // ----------------------------------------
    // Declarations
    // ----------------------------------------
    reg [15:0] ctrl_r;
    reg [15:0] topBuf_r;
    reg [15:0] topAct_r;
    reg [15:0] count_r;
    reg countDown_r;
    reg [3:0] preCnt_r;
    reg ovf_r;
    reg [1:0] phIdx_r;
    reg [31:0] prdata_r;
    reg [31:0] rdMux;
    reg addrOk;
    reg [3:0] phEn;
    reg [1:0] phLast;
    wire [19:0] ctlFlat;
    wire [63:0] valFlat;
    wire [3:0] ctcHit;
    wire [3:0] outVec;
    wire [31:0] statWord;

    wire run = ctrl_r[`TCWP_CTRL_RUN];
    wire crs = ctrl_r[`TCWP_CTRL_CRS];
    wire [1:0] cm = ctrl_r[`TCWP_CTRL_CM_HI:`TCWP_CTRL_CM_LO];
    wire [2:0] phase_mode_field = ctrl_r[`TCWP_CTRL_PHS_HI:`TCWP_CTRL_PHS_LO];
    wire phase_direction = ctrl_r[`TCWP_CTRL_PHASE_DIRECTION];
    wire [3:0] timer_prescale = ctrl_r[`TCWP_CTRL_TPS_HI:`TCWP_CTRL_TPS_LO];

    // ----------------------------------------
    // APB decode
    // ----------------------------------------
    wire setup = psel & ~penable;
    wire access = psel & penable;

    // ----------------------------------------
    // Write strobes
    // ----------------------------------------
    wire wr = access & pwrite & addrOk;
    wire wrCtrl = wr & (paddr == `TCWP_CTRL_ADDR);
    wire wrTop = wr & (paddr == `TCWP_TOP_ADDR);
    wire wrCount = wr & (paddr == `TCWP_COUNT_ADDR);
    wire wrStat = wr & (paddr == `TCWP_STAT_ADDR);

    // ----------------------------------------
    // Bus answer and pins
    // ----------------------------------------
    assign pready = penable;
    assign pslverr = access & ~addrOk;
    assign prdata = prdata_r;
    assign timerOverflowFlag = ovf_r;
    assign channelOutput = outVec;

    // ----------------------------------------
    // Status word
    // ----------------------------------------
    assign statWord = {24'h000000, phIdx_r, outVec, countDown_r, ovf_r};

    // ----------------------------------------
    // Prescaler and timer events
    // ----------------------------------------
    wire tick = run & (preCnt_r == timer_prescale);
    wire symMode = ~crs & cm[1];
    wire [15:0] upTop = crs ? `TCWP_FULL_TOP : topAct_r;
    wire atTop = (count_r == upTop);
    wire ctcClr = |ctcHit;
    wire topEvt = tick & symMode & ~countDown_r & (count_r >= topAct_r);
    wire undEvt = tick & symMode & countDown_r & (count_r == 16'h0000);
    wire wrapEvt = tick & ~symMode & atTop;
    wire periodEvt = symMode ? undEvt : wrapEvt;
    wire loadEvt = symMode ? (undEvt | ((cm == `TCWP_CM_PC) & topEvt)) : wrapEvt;

    // ----------------------------------------
    // Prescaler, restarts whenever the timer stops
    // ----------------------------------------
    always @(posedge clk) begin
        if (reset || !run || tick) begin
            preCnt_r <= 4'h0;
        end else begin
            preCnt_r <= preCnt_r + 4'h1;
        end
    end

    // ----------------------------------------
    // Timer counter
    // ----------------------------------------
    always @(posedge clk) begin
        if (reset) begin
            count_r <= 16'h0000;
            countDown_r <= 1'b0;
            topAct_r <= `TCWP_TOP_RST;
        end else begin
            if (periodEvt) begin
                topAct_r <= topBuf_r;
            end
            // A count write restarts the up slope
            if (wrCount) begin
                count_r <= pwdata[15:0];
                countDown_r <= 1'b0;
            end else if (tick && symMode) begin
                if (!countDown_r) begin
                    // Turn around at top, top shown for one tick
                    if (count_r >= topAct_r) begin
                        count_r <= count_r - 16'h0001;
                        countDown_r <= 1'b1;
                    end else begin
                        count_r <= count_r + 16'h0001;
                    end
                end else if (count_r == 16'h0000) begin
                    count_r <= 16'h0001;
                    countDown_r <= 1'b0;
                end else begin
                    count_r <= count_r - 16'h0001;
                end
            end else if (tick) begin
                countDown_r <= 1'b0;
                // Wrap at top or on a clear-on-match hit
                if (atTop || ctcClr) begin
                    count_r <= 16'h0000;
                end else begin
                    count_r <= count_r + 16'h0001;
                end
            end
        end
    end

    // ----------------------------------------
    // Overflow flag, set wins over clear
    // ----------------------------------------
    always @(posedge clk) begin
        if (reset) begin
            ovf_r <= 1'b0;
        end else if (loadEvt) begin
            ovf_r <= 1'b1;
        end else if (wrStat && pwdata[0]) begin
            ovf_r <= 1'b0;
        end
    end

    // ----------------------------------------
    // Control and top registers
    // ----------------------------------------
    always @(posedge clk) begin
        if (reset) begin
            ctrl_r <= `TCWP_CTRL_RST;
            topBuf_r <= `TCWP_TOP_RST;
        end else begin
            if (wrCtrl) begin
                ctrl_r <= pwdata[15:0];
            end
            if (wrTop) begin
                topBuf_r <= pwdata[15:0];
            end
        end
    end

    // ----------------------------------------
    // Multi-phase sequencer
    // ----------------------------------------
    always @* begin
        phEn = 4'hf;
        phLast = 2'h0;
        case (phase_mode_field)
            `TCWP_PHS_1OF2: begin
                phLast = 2'h1;
                phEn[0] = (phIdx_r == 2'h0);
                phEn[1] = (phIdx_r == 2'h1);
            end
            `TCWP_PHS_1OF3: begin
                phLast = 2'h2;
                phEn[0] = (phIdx_r == 2'h0);
                phEn[1] = (phIdx_r == 2'h1);
                phEn[2] = (phIdx_r == 2'h2);
            end
            `TCWP_PHS_1OF4: begin
                phLast = 2'h3;
                phEn[0] = (phIdx_r == 2'h0);
                phEn[1] = (phIdx_r == 2'h1);
                phEn[2] = (phIdx_r == 2'h2);
                phEn[3] = (phIdx_r == 2'h3);
            end
            `TCWP_PHS_2OF4: begin
                phLast = 2'h1;
                phEn[0] = (phIdx_r == 2'h0);
                phEn[2] = (phIdx_r == 2'h0);
                phEn[1] = (phIdx_r == 2'h1);
                phEn[3] = (phIdx_r == 2'h1);
            end
            default: begin
                phEn = 4'hf;
                phLast = 2'h0;
            end
        endcase
    end

    // ----------------------------------------
    // Phase index
    // ----------------------------------------
    always @(posedge clk) begin
        if (reset) begin
            phIdx_r <= 2'h0;
        end else if (!run) begin
            // Parked on the first slot of the chosen direction
            phIdx_r <= phase_direction ? phLast : 2'h0;
        end else if (periodEvt && phase_mode_field != `TCWP_PHS_OFF) begin
            if (phase_direction) begin
                phIdx_r <= (phIdx_r == 2'h0) ? phLast : phIdx_r - 2'h1;
            end else begin
                phIdx_r <= (phIdx_r == phLast) ? 2'h0 : phIdx_r + 2'h1;
            end
        end
    end

    // ----------------------------------------
    // Compare channels
    // ----------------------------------------
    genvar i;
    generate
        for (i = 0; i < 4; i = i + 1) begin : gCh
            localparam integer IDX = i;
            reg [4:0] ctl_r;
            reg [15:0] val_r;
            reg [15:0] act_r;
            reg out_r;
            wire ccm = ctl_r[`TCWP_CH_CCM];
            wire [2:0] act = ctl_r[`TCWP_CH_ACT_HI:`TCWP_CH_ACT_LO];
            wire isPwm = ccm & (act[2:1] == `TCWP_ACT_PWM);
            wire nonInv = act[0];
            wire [15:0] cmpCur = isPwm ? act_r : val_r;
            wire inRange = (cmpCur <= upTop);
            wire match = tick & inRange & (count_r == cmpCur);
            // Slots switched off by the sequencer compare at active top
            wire [15:0] cmpEff = phEn[i] ? act_r : topAct_r;
            wire chWr = wr & (paddr[3:2] == IDX[1:0]);

            assign ctcHit[i] = match & ccm & ctl_r[`TCWP_CH_CTC] & ~symMode;
            assign outVec[i] = out_r;
            assign ctlFlat[5*i +: 5] = ctl_r;
            assign valFlat[16*i +: 16] = val_r;

            // ----------------------------------------
            // Channel registers
            // ----------------------------------------
            always @(posedge clk) begin
                if (reset) begin
                    ctl_r <= 5'h00;
                    val_r <= 16'h0000;
                end else begin
                    if (chWr && paddr[7:4] == `TCWP_CHCTL_PAGE) begin
                        ctl_r <= pwdata[4:0];
                    end
                    if (chWr && paddr[7:4] == `TCWP_CHVAL_PAGE) begin
                        val_r <= pwdata[15:0];
                    end
                end
            end

            // ----------------------------------------
            // Compare buffer
            // ----------------------------------------
            always @(posedge clk) begin
                if (reset) begin
                    act_r <= 16'h0000;
                // Outside PWM the written value applies at once
                end else if (!isPwm || loadEvt) begin
                    act_r <= val_r;
                end
            end

            // ----------------------------------------
            // Output stage
            // ----------------------------------------
            always @(posedge clk) begin
                if (reset) begin
                    out_r <= 1'b1;
                end else if (tick && isPwm && !symMode) begin
                    if (count_r == 16'h0000) begin
                        out_r <= (cmpEff == 16'h0000) ~^ nonInv;
                    end else if (count_r == cmpEff && cmpEff < topAct_r) begin
                        out_r <= nonInv;
                    end
                end else if (tick && isPwm) begin
                    if (cmpEff >= topAct_r) begin
                        out_r <= nonInv;
                    end else if (cmpEff == 16'h0000) begin
                        out_r <= ~nonInv;
                    end else if (count_r == cmpEff) begin
                        out_r <= countDown_r ~^ nonInv;
                    end
                end else if (match && ccm) begin
                    case (act)
                        `TCWP_ACT_SET: out_r <= 1'b1;
                        `TCWP_ACT_CLR: out_r <= 1'b0;
                        `TCWP_ACT_TGL: out_r <= ~out_r;
                        default: out_r <= out_r;
                    endcase
                end
            end
        end
    endgenerate

    // ----------------------------------------
    // Read mux, captured in the setup cycle
    // ----------------------------------------
    always @* begin
        rdMux = 32'h0000_0000;
        addrOk = (paddr[1:0] == 2'h0);
        case (paddr[7:4])
            4'h0: begin
                case (paddr[3:2])
                    2'h0: rdMux = {16'h0000, ctrl_r};
                    2'h1: rdMux = {16'h0000, topBuf_r};
                    2'h2: rdMux = {16'h0000, count_r};
                    default: rdMux = statWord;
                endcase
            end
            `TCWP_CHCTL_PAGE: rdMux = {27'h0000000, ctlFlat[5*paddr[3:2] +: 5]};
            `TCWP_CHVAL_PAGE: rdMux = {16'h0000, valFlat[16*paddr[3:2] +: 16]};
            default: addrOk = 1'b0;
        endcase
    end

    always @(posedge clk) begin
        if (reset) begin
            prdata_r <= 32'h0000_0000;
        end else if (setup && !pwrite) begin
            // Refused reads return zero
            prdata_r <= addrOk ? rdMux : 32'h0000_0000;
        end
    end

endmodule
